// [frs_front_end_model.sv]
// frs_front_end_model: comparator front end of the power stage
// assumes: bench sets supply in tenths of a volt, pins in millivolts
`default_nettype none

module frs_front_end_model #(
   parameter int START_DV = 160,
   parameter int SHORT_DV = 10,
   parameter int MIN_DV   = 100,
   parameter int STOP_DV  = 90,
   parameter int OVER_DV  = 259,
   parameter int ON_MV    = 800,
   parameter int OFF_MV   = 700,
   parameter int EN_MV    = 100,
   parameter int HIGH_MV  = 2000,
   parameter int UP_MV    = 2500,
   parameter int LO_MV    = 400
) (
   // analog levels
   input  wire logic [15:0] vcc_dv,
   input  wire logic [15:0] line_mv,
   input  wire logic [15:0] fault_mv,
   // line flags
   output logic             line_ok,
   output logic             line_low,
   output logic             line_dead,
   output logic             line_hi,
   // supply flags
   output logic             vcc_start,
   output logic             vcc_short,
   output logic             vcc_min,
   output logic             vcc_stop,
   output logic             vcc_over,
   // fault pin flags
   output logic             flt_up,
   output logic             flt_lo
);
   timeunit 1ns;
   timeprecision 1ps;
   // ---------------------------------------------------------------
   // comparators, no hysteresis: bench steps clear every threshold
   // ---------------------------------------------------------------
   assign line_ok   = int'(line_mv) >= ON_MV;
   assign line_low  = int'(line_mv) < OFF_MV;
   assign line_dead = int'(line_mv) < EN_MV;
   assign line_hi   = int'(line_mv) >= HIGH_MV;
   assign vcc_start = int'(vcc_dv) >= START_DV;
   assign vcc_short = int'(vcc_dv) >= SHORT_DV;
   assign vcc_min   = int'(vcc_dv) >= MIN_DV;
   assign vcc_stop  = int'(vcc_dv) >= STOP_DV;
   assign vcc_over  = int'(vcc_dv) >= OVER_DV;
   assign flt_up    = int'(fault_mv) > UP_MV;
   assign flt_lo    = int'(fault_mv) < LO_MV;
endmodule // frs_front_end_model

`default_nettype wire

// [frs_pkg.sv]
// frs_pkg: constants for the converter fault and restart supervisor
// assumes: a single 50 MHz clock; every count is in cycles of that clock
`default_nettype none

package frs_pkg;

   // ---------------------------------------------------------------
   // clock and times
   // ---------------------------------------------------------------
   localparam int CLOCK_HZ        = 50_000_000;
   localparam int LINE_FILTER_MS  = 50;
   localparam int OCP_TIMER_MS    = 15;
   localparam int AUTOREC_S       = 1;
   localparam int FAULT_FILTER_US = 10;
   localparam int FAULT_CONFIRM   = 4;

   localparam int LINE_FILTER_CYC = CLOCK_HZ / 1000 * LINE_FILTER_MS;
   localparam int OCP_TIMER_CYC   = CLOCK_HZ / 1000 * OCP_TIMER_MS;
   localparam int AUTOREC_CYC     = CLOCK_HZ * AUTOREC_S;
   localparam int FAULT_FILTER_CYC = CLOCK_HZ / 1_000_000 * FAULT_FILTER_US;

   // ---------------------------------------------------------------
   // counter widths and soft-start divide
   // ---------------------------------------------------------------
   localparam int LINE_CNT_W  = 22;
   localparam int OCP_CNT_W   = 20;
   localparam int AR_CNT_W    = 26;
   localparam int FLT_CNT_W   = 9;
   localparam int CONF_CNT_W  = 3;
   localparam int LEVEL_W     = 10;
   localparam int SS_DIV_SHIFT = 2;   // divide by four
   localparam int FLAG_COUNT  = 13;

   // ---------------------------------------------------------------
   // register port
   // ---------------------------------------------------------------
   localparam logic [3:0] CTRL_ADDR   = 4'h0;
   localparam logic [3:0] STATUS_ADDR = 4'h4;
   localparam int CTRL_AUTO_BIT  = 0;
   localparam int CTRL_OFF_BIT   = 1;
   localparam logic CTRL_OFF_RESET = 1'b0;

   // ---------------------------------------------------------------
   // sequencer states, one-hot
   // ---------------------------------------------------------------
   typedef enum logic [4:0] {
      ST_WAIT    = 5'h01,
      ST_RUN     = 5'h02,
      ST_HICCUP  = 5'h04,
      ST_LATCHED = 5'h08,
      ST_BROWN   = 5'h10
   } frs_state_t;

endpackage

`default_nettype wire

// [frs_supervisor.sv]
// frs_supervisor: protection and restart sequencer of the converter
// assumes: comparator flags are asynchronous levels; level buses are
// sampled codes synchronous to clock; register port master never waits
//
// Our own choices: the strobed register port and the register addresses.
`default_nettype none

// ------------------------------------------------------------------
// Function
// [R1] brown-out stops gate pulses; no restart until line is acceptable
// [R2] line recovery issues general reset clearing latches, then allows restart
// [R3] restart on rising supply start crossing, or at once if already above
// [R4] brown-out declared only after line stays low for the filter time
// [R5] start-up source on at start, off after; self-supply re-enables on dips
// [R6] frequency jitter enabled only at high line
// [R7] soft-start at every start-up, hiccup retry and after brown-out
// [R8] feedback below skip forces zero duty, pulses resume when it clears
// [R9] fault pin overvoltage latches off; only general reset releases it
// [R10] fault pin below lower threshold disables pulsing
// [R11] supply overvoltage stops pulses at once and enters auto-recovery
// [R12] peak limit raises overload flag; overcurrent timer runs while set
// [R13] validated overload: auto variant stops pulses, hiccups with soft-start
// [R14] hiccup keeps pulses off for the off time before the next retry
// [R15] build option selects hiccup recovery or latch-off on overload
// [R16] start-up source reduced below short-detect level, full above it
// [R17] soft-start setpoint is node over four while below feedback
// [R18] soft-start node grounded after any fault and during brown-out; here only outside ST_RUN, so an unlatched fault pin low leaves it released
// [R19] overload validated only after flag held for the overcurrent time
// [R20] during off timer, supply start crossings are ignored
// [R21] fault pin latches after filter time then four confirming cycles
// [R22] line low at first minimum-level crossing disables line functions
// [R23] comparator flags synchronised; all timers count the clock
// [R24] reset clears latches, gate off, soft-start grounded, source on
// ------------------------------------------------------------------

module frs_supervisor #(
   parameter int  LINE_FILTER_CYCLES = frs_pkg::LINE_FILTER_CYC,
   parameter int  OCP_TIMER_CYCLES   = frs_pkg::OCP_TIMER_CYC,
   parameter int  AUTOREC_CYCLES     = frs_pkg::AUTOREC_CYC,
   parameter logic AUTO_RECOVER      = 1'b1
) (
   // clock and reset
   input  wire logic        clock,
   input  wire logic        rst_n,
   // line sense comparators
   input  wire logic        line_above_turnon,
   input  wire logic        line_below_turnoff,
   input  wire logic        line_below_enable,
   input  wire logic        line_high,
   // supply comparators
   input  wire logic        supply_above_start,
   input  wire logic        supply_above_short_detect,
   input  wire logic        supply_above_minimum,
   input  wire logic        supply_above_stop,
   input  wire logic        supply_above_over,
   // fault pin, current and feedback comparators
   input  wire logic        fault_pin_above_upper,
   input  wire logic        fault_pin_below_lower,
   input  wire logic        peak_limit_reached,
   input  wire logic        feedback_below_skip,
   // sampled levels for soft-start setpoint
   input  wire logic [9:0]  soft_start_level,
   input  wire logic [9:0]  feedback_level,
   input  wire logic [9:0]  current_sense_level,
   // register port
   input  wire logic [3:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_write,
   input  wire logic        reg_read,
   output logic      [31:0] reg_rdata,
   // power stage controls
   output logic             gate_enable,
   output logic             on_time_stop,
   output logic             hv_source_enable,
   output logic             hv_full_current,
   output logic             soft_start_discharge,
   output logic             jitter_enable
);

   // ---------------------------------------------------------------
   // flag synchronisers
   // ---------------------------------------------------------------
   logic [frs_pkg::FLAG_COUNT-1:0] flags_sync;
   logic s_line_ok, s_line_low, s_line_en_low, s_line_high;
   logic s_start, s_short, s_min, s_stop, s_over;
   logic s_flt_high, s_flt_low, s_peak, s_skip;

   frs_sync #(
      .WIDTH (frs_pkg::FLAG_COUNT)
   ) u_sync (
      .clock    (clock),
      .rst_n    (rst_n),
      .async_in ({line_above_turnon, line_below_turnoff,
                  line_below_enable, line_high, supply_above_start,
                  supply_above_short_detect, supply_above_minimum,
                  supply_above_stop, supply_above_over,
                  fault_pin_above_upper, fault_pin_below_lower,
                  peak_limit_reached, feedback_below_skip}),
      .sync_out (flags_sync)
   ); // R23

   assign {s_line_ok, s_line_low, s_line_en_low, s_line_high, s_start,
           s_short, s_min, s_stop, s_over, s_flt_high, s_flt_low,
           s_peak, s_skip} = flags_sync;

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      frs_pkg::frs_state_t               state;
      logic                              start_prev;
      logic                              min_prev;
      logic                              start_now;
      logic                              line_armed;
      logic                              line_off;
      logic                              brown;
      logic [frs_pkg::LINE_CNT_W-1:0]    line_cnt;
      logic [frs_pkg::FLT_CNT_W-1:0]     flt_cnt;
      logic [frs_pkg::CONF_CNT_W-1:0]    conf_cnt;
      logic                              flt_latched;
      logic                              overload;
      logic [frs_pkg::OCP_CNT_W-1:0]     ocp_cnt;
      logic [frs_pkg::AR_CNT_W-1:0]      ar_cnt;
      logic                              auto_mode;
      logic                              sw_off;
      logic                              gate;
      logic                              on_stop;
      logic                              hv_en;
      logic                              hv_full;
      logic                              ss_dis;
      logic                              jitter;
      logic [31:0]                       rdata;
   } frs_sup_t;

   frs_sup_t q;
   frs_sup_t next_q;

   logic start_edge;
   logic gen_reset;
   logic brown_fire;
   logic fault_any;
   logic ocp_done;
   logic ar_done;

   assign start_edge = s_start && !q.start_prev;
   assign gen_reset  = q.brown && s_line_ok;
   assign brown_fire = !q.brown && !q.line_off && s_line_low
      && (q.line_cnt == frs_pkg::LINE_CNT_W'(LINE_FILTER_CYCLES - 1));
   assign fault_any  = s_flt_high || s_flt_low;
   assign ocp_done   = q.overload
      && (q.ocp_cnt == frs_pkg::OCP_CNT_W'(OCP_TIMER_CYCLES - 1));
   assign ar_done    =
      (q.ar_cnt == frs_pkg::AR_CNT_W'(AUTOREC_CYCLES - 1));

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      next_q = q;
      next_q.start_prev = s_start;
      next_q.min_prev   = s_min;

      // line sense enable caught once per power-on
      if (q.line_armed && s_min && !q.min_prev) begin
         next_q.line_armed = 1'b0;
         next_q.line_off   = s_line_en_low; // R22
      end

      // brown-out filter; a single high sample restarts it
      if (!q.brown && !q.line_off && s_line_low) begin
         next_q.line_cnt = q.line_cnt + 1'b1; // R4
      end else begin
         next_q.line_cnt = '0;
      end
      if (brown_fire) begin
         next_q.brown = 1'b1; // R4
      end

      // fault pin: filter, then consecutive confirmation
      if (!fault_any) begin
         next_q.flt_cnt  = '0;
         next_q.conf_cnt = '0;
      end else if (q.flt_cnt !=
                   frs_pkg::FLT_CNT_W'(frs_pkg::FAULT_FILTER_CYC)) begin
         next_q.flt_cnt = q.flt_cnt + 1'b1; // R21
      end else if (q.conf_cnt !=
                   frs_pkg::CONF_CNT_W'(frs_pkg::FAULT_CONFIRM - 1)) begin
         next_q.conf_cnt = q.conf_cnt + 1'b1; // R21
      end else begin
         next_q.flt_latched = 1'b1; // R9 R10 R21
      end

      // overload flag and overcurrent timer
      next_q.overload = s_peak && (q.state == frs_pkg::ST_RUN); // R12
      if (q.overload && !ocp_done) begin
         next_q.ocp_cnt = q.ocp_cnt + 1'b1; // R12 R19
      end else begin
         next_q.ocp_cnt = '0;
      end

      // sequencer
      if (brown_fire) begin
         next_q.state = frs_pkg::ST_BROWN; // R1
      end else begin
         case (q.state)
            frs_pkg::ST_WAIT: begin
               if (q.flt_latched) begin
                  next_q.state = frs_pkg::ST_LATCHED; // R9
               end else if ((start_edge || q.start_now) && !q.sw_off) begin
                  next_q.state     = frs_pkg::ST_RUN; // R3 R7
                  next_q.start_now = 1'b0;
               end
            end
            frs_pkg::ST_RUN: begin
               if (q.flt_latched) begin
                  next_q.state = frs_pkg::ST_LATCHED; // R9
               end else if (s_over) begin
                  next_q.state = frs_pkg::ST_HICCUP; // R11
               end else if (ocp_done) begin
                  next_q.state = q.auto_mode ? frs_pkg::ST_HICCUP
                                             : frs_pkg::ST_LATCHED; // R15 R13
               end else if (!s_stop || q.sw_off) begin
                  next_q.state = frs_pkg::ST_WAIT; // R18
               end
            end
            frs_pkg::ST_HICCUP: begin
               // start crossings are not looked at here
               if (q.flt_latched) begin
                  next_q.state = frs_pkg::ST_LATCHED;
               end else if (ar_done) begin
                  next_q.state = frs_pkg::ST_WAIT; // R14 R20
               end
            end
            frs_pkg::ST_BROWN: begin
               if (gen_reset) begin
                  next_q.state     = frs_pkg::ST_WAIT; // R2
                  next_q.start_now = s_start; // R3
               end
            end
            frs_pkg::ST_LATCHED: begin
               next_q.state = frs_pkg::ST_LATCHED; // R9
            end
            default: begin
               next_q.state = frs_pkg::ST_WAIT;
            end
         endcase
      end

      // off timer runs only inside hiccup
      if (q.state == frs_pkg::ST_HICCUP && !ar_done) begin
         next_q.ar_cnt = q.ar_cnt + 1'b1; // R14
      end else begin
         next_q.ar_cnt = '0;
      end

      // general reset releases every latched fault
      if (gen_reset) begin
         next_q.brown       = 1'b0; // R2
         next_q.flt_latched = 1'b0; // R2
         next_q.flt_cnt     = '0;
         next_q.conf_cnt    = '0;
         next_q.ocp_cnt     = '0;
         next_q.ar_cnt      = '0;
      end

      // start-up source with self-supply hysteresis
      if (!s_min) begin
         next_q.hv_en = 1'b1; // R5
      end else if (s_start) begin
         next_q.hv_en = 1'b0; // R5
      end
      next_q.hv_full = s_short; // R16

      // pulse permission and soft-start node
      next_q.gate = (next_q.state == frs_pkg::ST_RUN) && !s_skip
         && !s_over && !s_flt_low && !brown_fire; // R8 R10 R11 R1
      next_q.ss_dis = (next_q.state != frs_pkg::ST_RUN); // R18 R7
      next_q.on_stop = (q.state == frs_pkg::ST_RUN)
         && (soft_start_level < feedback_level)
         && (current_sense_level >
             (soft_start_level >> frs_pkg::SS_DIV_SHIFT)); // R17
      next_q.jitter = s_line_high && !q.line_off; // R6

      // register port; read data valid the cycle after the strobe
      next_q.rdata = '0;
      if (reg_write && reg_addr == frs_pkg::CTRL_ADDR) begin
         next_q.auto_mode = reg_wdata[frs_pkg::CTRL_AUTO_BIT]; // R15
         next_q.sw_off    = reg_wdata[frs_pkg::CTRL_OFF_BIT];
      end
      if (reg_read) begin
         if (reg_addr == frs_pkg::CTRL_ADDR) begin
            next_q.rdata = {30'h0, q.sw_off, q.auto_mode};
         end else if (reg_addr == frs_pkg::STATUS_ADDR) begin
            next_q.rdata = {22'h0, q.line_off, q.flt_latched,
                            q.overload, q.brown, 1'b0, q.state};
         end
      end
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         q             <= '0; // R24
         q.state       <= frs_pkg::ST_WAIT;
         q.line_armed  <= 1'b1;
         q.hv_en       <= 1'b1; // R24
         q.ss_dis      <= 1'b1; // R24
         q.auto_mode   <= AUTO_RECOVER;
         q.sw_off      <= frs_pkg::CTRL_OFF_RESET;
      end else begin
         q <= next_q;
      end
   end

   assign gate_enable          = q.gate;
   assign on_time_stop         = q.on_stop;
   assign hv_source_enable     = q.hv_en;
   assign hv_full_current      = q.hv_full;
   assign soft_start_discharge = q.ss_dis;
   assign jitter_enable        = q.jitter;
   assign reg_rdata            = q.rdata;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   a_brown_stops_gate: assert property ( // R1
      q.brown |=> !gate_enable)
      else $error("gate enabled during brown-out");
   a_general_reset: assert property ( // R2
      gen_reset |=> !q.flt_latched && q.state == frs_pkg::ST_WAIT)
      else $error("general reset left a latch set");
   a_restart_now: assert property ( // R3
      gen_reset && s_start ##1 !q.sw_off && !brown_fire
      |=> q.state == frs_pkg::ST_RUN)
      else $error("restart not immediate after line recovery");
   a_skip_no_pulse: assert property ( // R8
      s_skip |=> !gate_enable)
      else $error("gate enabled while feedback below skip");
   a_latch_holds: assert property ( // R9
      q.state == frs_pkg::ST_LATCHED && !gen_reset && !brown_fire
      |=> q.state == frs_pkg::ST_LATCHED)
      else $error("latched state left without general reset");
   a_over_stops: assert property ( // R11
      s_over |=> !gate_enable)
      else $error("gate enabled during supply overvoltage");
   a_hiccup_wait: assert property ( // R20
      q.state == frs_pkg::ST_HICCUP && !ar_done && !brown_fire
      && !q.flt_latched |=> q.state == frs_pkg::ST_HICCUP)
      else $error("hiccup left before off timer elapsed");
   a_hiccup_ground: assert property ( // R18
      q.state == frs_pkg::ST_HICCUP |=> soft_start_discharge)
      else $error("soft-start released during hiccup");
   a_fault_confirm: assert property ( // R21
      $rose(q.flt_latched) |-> $past(fault_any, 1) && $past(fault_any, 4))
      else $error("fault latched without confirming cycles");
   a_reduced_source: assert property ( // R16
      !s_short |=> !hv_full_current)
      else $error("full start-up current below short-detect level");
   a_jitter_low_line: assert property ( // R6
      !s_line_high |=> !jitter_enable)
      else $error("jitter enabled at low line");

endmodule // frs_supervisor

`default_nettype wire

// [frs_sync.sv]
// frs_sync: two-flop synchroniser for a vector of independent flags
// assumes: each bit is a slow level; bits need not be coherent
`default_nettype none

module frs_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input  wire logic             clock,
   input  wire logic             rst_n,
   // flags
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   typedef struct packed {
      logic [WIDTH-1:0] first;
      logic [WIDTH-1:0] second;
   } frs_sync_t;

   frs_sync_t q;
   frs_sync_t next_q;

   always_comb begin
      next_q.first  = async_in;
      next_q.second = q.first;
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign sync_out = q.second;

endmodule // frs_sync

`default_nettype wire

// [tb_converter_fault_restart_supervisor.sv]
// tb_converter_fault_restart_supervisor: self-checking bench
// assumes: short timer parameters; front end model makes the line, supply and fault pin flags; bench drives peak and skip
`default_nettype none

module tb_converter_fault_restart_supervisor;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [15:0] V_UP = 16'h00aa, V_MID = 16'h0078,
      V_LOW = 16'h0050, V_OVR = 16'h010e, V_SOFT = 16'h0032;
   localparam logic [15:0] L_OK = 16'h0384, L_HI = 16'h09c4,
      F_OK = 16'h04b0, F_OVP = 16'h0bb8, F_OTP = 16'h0064;
   logic        clock, rst_n, peak, skip, reg_write, reg_read;
   logic [15:0] vcc, line, flt;
   logic [9:0]  ss, fb, cs;
   logic [3:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata, rd;
   logic        l_on, l_off, l_en, l_hi, s_st, s_sh, s_mn, s_sp, s_ov;
   logic        f_up, f_lo, gate, ots, hv_en, hv_full, ss_dis, jit;
   int          num_errors = 0, check_count = 0, n, k;
   int          seed = 32'h2a5b7ea1;

   frs_front_end_model FE (.vcc_dv(vcc), .line_mv(line),
      .fault_mv(flt), .line_ok(l_on), .line_low(l_off),
      .line_dead(l_en), .line_hi(l_hi), .vcc_start(s_st),
      .vcc_short(s_sh), .vcc_min(s_mn), .vcc_stop(s_sp),
      .vcc_over(s_ov), .flt_up(f_up), .flt_lo(f_lo));

   frs_supervisor #(.LINE_FILTER_CYCLES(20), .OCP_TIMER_CYCLES(16),
      .AUTOREC_CYCLES(40), .AUTO_RECOVER(1'b1)) DUT (
      .clock(clock), .rst_n(rst_n), .line_above_turnon(l_on),
      .line_below_turnoff(l_off), .line_below_enable(l_en),
      .line_high(l_hi), .supply_above_start(s_st),
      .supply_above_short_detect(s_sh), .supply_above_minimum(s_mn),
      .supply_above_stop(s_sp), .supply_above_over(s_ov),
      .fault_pin_above_upper(f_up), .fault_pin_below_lower(f_lo),
      .peak_limit_reached(peak), .feedback_below_skip(skip),
      .soft_start_level(ss), .feedback_level(fb),
      .current_sense_level(cs), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_read(reg_read), .reg_rdata(reg_rdata), .gate_enable(gate),
      .on_time_stop(ots), .hv_source_enable(hv_en),
      .hv_full_current(hv_full), .soft_start_discharge(ss_dis),
      .jitter_enable(jit));

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, g);
      check_count++;
      if (g !== e) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk1(input string nm, input logic e, g);
      chk(nm, {31'h0, e}, {31'h0, g});
   endtask
   // sample one step after the edge so the edge's updates have landed
   task automatic cyc(input int c);
      repeat (c) @(posedge clock);
      #1;
   endtask
   task automatic wgate(input logic e);
      for (n = 0; n < 60 && gate !== e; n++) cyc(1);
      chk1("gate_enable", e, gate);
      if (gate !== e) tally_and_finish();
   endtask
   task automatic rreg(input logic [3:0] a);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      #1;
      rd = reg_rdata;
   endtask
   task automatic wreg(input logic [3:0] a, input logic [31:0] d);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
      cyc(1);
   endtask
   task automatic st(input frs_pkg::frs_state_t e);
      rreg(frs_pkg::STATUS_ADDR);
      chk("state", {27'h0, e}, {27'h0, rd[4:0]});
   endtask
   // a fresh rising crossing of the start level
   task automatic rise();
      vcc <= V_MID;
      cyc(5);
      vcc <= V_UP;
      cyc(5);
   endtask
   task automatic brown();
      line <= 16'h0000;
      cyc(30);
      line <= L_OK;
   endtask
   function automatic logic exp_stop(input logic [9:0] s, f, c);
      return (s < f) && (c > (s >> 2));
   endfunction
   task automatic ost(input logic [9:0] s, f, c);
      ss <= s;
      fb <= f;
      cs <= c;
      cyc(3);
      chk1("on_time_stop", exp_stop(s, f, c), ots);
   endtask

   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      rst_n = 1'b0; vcc = 16'h0; line = L_OK; flt = F_OK;
      peak = 1'b0; skip = 1'b0; ss = 10'h0; fb = 10'h0; cs = 10'h0;
      reg_addr = 4'h0; reg_wdata = 32'h0;
      reg_write = 1'b0; reg_read = 1'b0;
      cyc(5);
      rst_n <= 1'b1;
      cyc(1);
      chk1("gate_enable", 1'b0, gate);
      chk1("hv_source_enable", 1'b1, hv_en);
      chk1("soft_start_discharge", 1'b1, ss_dis);
      chk1("hv_full_current", 1'b0, hv_full);
      rreg(frs_pkg::CTRL_ADDR);
      chk("ctrl", 32'h1, rd);
      wreg(4'h8, 32'hffffffff);
      wreg(frs_pkg::STATUS_ADDR, 32'hffffffff);
      rreg(4'h8);
      chk("unmapped", 32'h0, rd);
      st(frs_pkg::ST_WAIT);
      vcc <= V_SOFT;
      cyc(5);
      chk1("hv_full_current", 1'b1, hv_full);
      rise();
      wgate(1'b1);
      chk1("soft_start_discharge", 1'b0, ss_dis);
      chk1("hv_source_enable", 1'b0, hv_en);
      chk1("jitter_enable", 1'b0, jit);
      line <= L_HI;
      cyc(6);
      chk1("jitter_enable", 1'b1, jit);
      line <= L_OK;
      cyc(6);
      chk1("jitter_enable", 1'b0, jit);
      ost(10'h064, 10'h0c8, 10'h019);
      ost(10'h064, 10'h0c8, 10'h01a);
      ost(10'h12c, 10'h0c8, 10'h0c8);
      repeat (16) ost(10'($random(seed)), 10'($random(seed)),
         10'($random(seed)));
      skip <= 1'b1;
      wgate(1'b0);
      skip <= 1'b0;
      wgate(1'b1);
      flt <= F_OTP;
      wgate(1'b0);
      flt <= F_OK;
      wgate(1'b1);
      flt <= F_OVP;
      cyc(400);
      flt <= F_OK;
      cyc(10);
      st(frs_pkg::ST_RUN);
      k = ($random(seed) & 7) + 4;
      peak <= 1'b1;
      cyc(k);
      peak <= 1'b0;
      cyc(6);
      st(frs_pkg::ST_RUN);
      peak <= 1'b1;
      wgate(1'b0);
      peak <= 1'b0;
      chk1("soft_start_discharge", 1'b1, ss_dis);
      st(frs_pkg::ST_HICCUP);
      rise();
      st(frs_pkg::ST_HICCUP);
      chk1("gate_enable", 1'b0, gate);
      cyc(40);
      st(frs_pkg::ST_WAIT);
      rise();
      wgate(1'b1);
      vcc <= V_OVR;
      wgate(1'b0);
      st(frs_pkg::ST_HICCUP);
      vcc <= V_MID;
      cyc(45);
      vcc <= V_UP;
      wgate(1'b1);
      vcc <= V_LOW;
      wgate(1'b0);
      chk1("soft_start_discharge", 1'b1, ss_dis);
      chk1("hv_source_enable", 1'b1, hv_en);
      vcc <= V_UP;
      wgate(1'b1);
      line <= 16'h0000;
      cyc(($random(seed) & 7) + 5);
      line <= L_OK;
      cyc(25);
      st(frs_pkg::ST_RUN);
      line <= 16'h0000;
      cyc(15);
      chk1("gate_enable", 1'b1, gate);
      wgate(1'b0);
      st(frs_pkg::ST_BROWN);
      chk1("soft_start_discharge", 1'b1, ss_dis);
      rise();
      chk1("gate_enable", 1'b0, gate);
      line <= L_OK;
      wgate(1'b1);
      wreg(frs_pkg::CTRL_ADDR, 32'h0);
      peak <= 1'b1;
      wgate(1'b0);
      peak <= 1'b0;
      st(frs_pkg::ST_LATCHED);
      rise();
      chk1("gate_enable", 1'b0, gate);
      brown();
      wgate(1'b1);
      wreg(frs_pkg::CTRL_ADDR, 32'h1);
      flt <= F_OVP;
      cyc(520);
      flt <= F_OK;
      st(frs_pkg::ST_LATCHED);
      rise();
      chk1("gate_enable", 1'b0, gate);
      brown();
      wgate(1'b1);
      // line held dead at the first minimum crossing after a reset
      rst_n <= 1'b0;
      vcc <= 16'h0000;
      line <= 16'h0000;
      cyc(5);
      rst_n <= 1'b1;
      rise();
      cyc(30);
      chk1("gate_enable", 1'b1, gate);
      rreg(frs_pkg::STATUS_ADDR);
      chk("status", 32'h202, rd);
      tally_and_finish();
   end
endmodule // tb_converter_fault_restart_supervisor

`default_nettype wire
